/* File: hw/fmh_defs.vh */
// register offsets, field positions, reset values for the fan stage controller
// included by the top controller file only; definitions only
`ifndef FMH_DEFS_VH
`define FMH_DEFS_VH

`define FMH_STAGES 5
`define FMH_OFF_CTRL 8'h00
`define FMH_OFF_SETP 8'h04
`define FMH_OFF_TEMP 8'h08
`define FMH_OFF_HYST 8'h0c
`define FMH_OFF_STAT 8'h10
`define FMH_OFF_OFFS_BASE 8'h20
`define FMH_OFF_PCT_BASE 8'h40
`define FMH_CTRL_COOL 0
`define FMH_CTRL_SCALE 1
`define FMH_CTRL_NLEV_LO 4
`define FMH_CTRL_NLEV_HI 6
`define FMH_RST_NLEV 3'h5
`define FMH_RST_SETP 16'h00c8
`define FMH_RST_TEMP 16'h00c8
`define FMH_RST_HYST 8'h01
`define FMH_RST_OFFS0 8'h00
`define FMH_RST_OFFS1 8'h0a
`define FMH_RST_OFFS2 8'h0f
`define FMH_RST_OFFS3 8'h14
`define FMH_RST_OFFS4 8'h1e
`define FMH_RST_PCT0 8'h01
`define FMH_RST_PCT1 8'h14
`define FMH_RST_PCT2 8'h32
`define FMH_RST_PCT3 8'h46
`define FMH_RST_PCT4 8'h5a

`endif

/* File: hw/fmh_stage.v */
// one two-point fan stage with its own hysteresis loop
// assumes temperatures and setpoint in signed 0.1 K units, offsets unsigned
`timescale 1ns/1ps
`default_nettype none

module fmh_stage (
    input wire clk_i,
    input wire rst_i,
    input wire eval_i,
    input wire enable_i,
    input wire cool_i,
    input wire kill_i,
    input wire [15:0] temp_i,
    input wire [15:0] setp_i,
    input wire [7:0] offs_i,
    input wire [7:0] hyst_i,
    output wire want_o,
    output wire act_d_o,
    output reg act_q_o
);
    wire signed [17:0] t;
    wire signed [17:0] s;
    wire signed [17:0] o;
    wire signed [17:0] h;
    wire signed [17:0] near;
    wire signed [17:0] far;
    wire on_req;
    wire off_cond;

    assign t = {{2{temp_i[15]}}, temp_i};
    assign s = {{2{setp_i[15]}}, setp_i};
    assign o = {10'h000, offs_i};
    assign h = {10'h000, hyst_i};
    // switch-off point and switch-on point of this stage
    assign near = cool_i ? (s + o) : (s - o);
    assign far = cool_i ? (near + h) : (near - h);
    assign on_req = cool_i ? (t > far) : (t < far);
    assign off_cond = cool_i ? (t <= near) : (t >= near);
    // inside the band the stage keeps its previous state
    assign want_o = enable_i & (on_req | (act_q_o & ~off_cond));
    assign act_d_o = want_o & ~kill_i;

    always @(posedge clk_i) begin
        if (rst_i) begin
            act_q_o <= 1'b0;
        end else if (eval_i) begin
            act_q_o <= act_d_o;
        end
    end
endmodule

`default_nettype wire

/* File: hw/fmh_ctrl.v */
// multi-stage two-point fan controller with a classic wishbone slave
// assumes one 10 MHz clock, synchronous active-high reset, wishbone master
// on the same clock
//
// Operation
// - up to five stages, each own hysteresis loop, all sharing one hyst_q width
// - heating: on below sp-off-hyst, off at sp-off
// - cooling: on above sp+off+hyst, off at sp+off
// - stage one off when higher stage needed
// - stage two off when stage three needed
// - stage one offset resets to zero kelvin
// - enumerated format sends speed number byte
// - scaling format sends level percentage byte
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fmh_defs.vh"

module fmh_ctrl (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg [7:0] fan_level_o,
    output reg fan_send_o
);
    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    reg cool_q;
    reg scale_q;
    reg [2:0] nlev_q;
    reg [15:0] setp_q;
    reg [15:0] temp_q;
    reg [7:0] hyst_q;
    reg [7:0] offs_q [0:4];
    reg [7:0] pct_q [0:4];
    reg eval_q;
    reg [2:0] lvl_q;

    wire req;
    wire wr;
    wire [2:0] idx;
    wire in_offs;
    wire in_pct;
    wire [4:0] want;
    wire [4:0] act_d;
    wire [4:0] act_q;
    wire [4:0] kill;
    reg [2:0] lvl_d;
    reg [7:0] val_d;
    reg [31:0] rdat_d;
    integer i;
    localparam [7:0] OFFS_BASE = `FMH_OFF_OFFS_BASE;
    localparam [7:0] PCT_BASE = `FMH_OFF_PCT_BASE;

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i;
    assign idx = wb_adr_i[4:2];
    assign in_offs = (wb_adr_i[7:5] == OFFS_BASE[7:5]) &&
                     (wb_adr_i[1:0] == 2'h0) && ({29'h0, idx} < `FMH_STAGES);
    assign in_pct = (wb_adr_i[7:5] == PCT_BASE[7:5]) &&
                    (wb_adr_i[1:0] == 2'h0) && ({29'h0, idx} < `FMH_STAGES);

    always @(posedge clk_i) begin
        if (rst_i) begin
            cool_q <= 1'b0;
            scale_q <= 1'b0;
            nlev_q <= `FMH_RST_NLEV;
            setp_q <= `FMH_RST_SETP;
            temp_q <= `FMH_RST_TEMP;
            hyst_q <= `FMH_RST_HYST;
            offs_q[0] <= `FMH_RST_OFFS0;
            offs_q[1] <= `FMH_RST_OFFS1;
            offs_q[2] <= `FMH_RST_OFFS2;
            offs_q[3] <= `FMH_RST_OFFS3;
            offs_q[4] <= `FMH_RST_OFFS4;
            pct_q[0] <= `FMH_RST_PCT0;
            pct_q[1] <= `FMH_RST_PCT1;
            pct_q[2] <= `FMH_RST_PCT2;
            pct_q[3] <= `FMH_RST_PCT3;
            pct_q[4] <= `FMH_RST_PCT4;
            eval_q <= 1'b0;
        end else begin
            eval_q <= 1'b0;
            if (wr && wb_sel_i[0]) begin
                case (wb_adr_i)
                    `FMH_OFF_CTRL: begin
                        cool_q <= wb_dat_i[`FMH_CTRL_COOL];
                        scale_q <= wb_dat_i[`FMH_CTRL_SCALE];
                        nlev_q <= wb_dat_i[`FMH_CTRL_NLEV_HI:`FMH_CTRL_NLEV_LO];
                    end
                    `FMH_OFF_SETP: begin
                        setp_q[7:0] <= wb_dat_i[7:0];
                        eval_q <= 1'b1;
                    end
                    `FMH_OFF_TEMP: begin
                        temp_q[7:0] <= wb_dat_i[7:0];
                        eval_q <= 1'b1;
                    end
                    `FMH_OFF_HYST: begin
                        hyst_q <= wb_dat_i[7:0];
                    end
                    default: begin
                        if (in_offs) begin
                            offs_q[idx] <= wb_dat_i[7:0];
                        end
                        if (in_pct) begin
                            pct_q[idx] <= wb_dat_i[7:0];
                        end
                    end
                endcase
            end
            if (wr && wb_sel_i[1]) begin
                if (wb_adr_i == `FMH_OFF_SETP) begin
                    setp_q[15:8] <= wb_dat_i[15:8];
                    eval_q <= 1'b1;
                end
                if (wb_adr_i == `FMH_OFF_TEMP) begin
                    temp_q[15:8] <= wb_dat_i[15:8];
                    eval_q <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // stages
    // ------------------------------------------------------------
    assign kill[0] = |want[4:1];
    assign kill[1] = want[2];
    assign kill[4:2] = 3'h0;

    genvar g;
    generate
        for (g = 0; g < `FMH_STAGES; g = g + 1) begin : gen_stage
            fmh_stage u_stage (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .eval_i(eval_q),
                .enable_i({29'h0, nlev_q} > g),
                .cool_i(cool_q),
                .kill_i(kill[g]),
                .temp_i(temp_q),
                .setp_i(setp_q),
                .offs_i(offs_q[g]),
                .hyst_i(hyst_q),
                .want_o(want[g]),
                .act_d_o(act_d[g]),
                .act_q_o(act_q[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // fan level selection and output
    // ------------------------------------------------------------
    always @* begin
        lvl_d = 3'h0;
        for (i = 0; i < `FMH_STAGES; i = i + 1) begin
            if (act_d[i]) begin
                lvl_d = i[2:0] + 3'h1;
            end
        end
        if (lvl_d == 3'h0) begin
            val_d = 8'h00;
        end else if (scale_q) begin
            val_d = pct_q[lvl_d - 3'h1];
        end else begin
            val_d = {5'h00, lvl_d};
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            lvl_q <= 3'h0;
            fan_level_o <= 8'h00;
            fan_send_o <= 1'b0;
        end else begin
            fan_send_o <= 1'b0;
            if (eval_q && (lvl_d != lvl_q)) begin
                lvl_q <= lvl_d;
                fan_level_o <= val_d;
                fan_send_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // wishbone read path
    // ------------------------------------------------------------
    always @* begin
        rdat_d = 32'h00000000;
        case (wb_adr_i)
            `FMH_OFF_CTRL: begin
                rdat_d[`FMH_CTRL_COOL] = cool_q;
                rdat_d[`FMH_CTRL_SCALE] = scale_q;
                rdat_d[`FMH_CTRL_NLEV_HI:`FMH_CTRL_NLEV_LO] = nlev_q;
            end
            `FMH_OFF_SETP: rdat_d[15:0] = setp_q;
            `FMH_OFF_TEMP: rdat_d[15:0] = temp_q;
            `FMH_OFF_HYST: rdat_d[7:0] = hyst_q;
            `FMH_OFF_STAT: begin
                rdat_d[4:0] = act_q;
                rdat_d[10:8] = lvl_q;
                rdat_d[23:16] = fan_level_o;
            end
            default: begin
                if (in_offs) begin
                    rdat_d[7:0] = offs_q[idx];
                end
                if (in_pct) begin
                    rdat_d[7:0] = pct_q[idx];
                end
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i) begin
                wb_dat_o <= rdat_d;
            end
        end
    end
endmodule

`default_nettype wire

/* File: dv/fmh_ctrl_assertions.sv */
// checker for the fan stage controller: bus timing and fan output
// bound to fmh_ctrl, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module fmh_ctrl_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [7:0] fan_level_o,
    input wire logic fan_send_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic wr_samp;
    // sample write seen acked; the fan output answers one edge later
    assign wr_samp = wb_ack_o && wb_we_i && (wb_sel_i[1:0] != 2'b00)
        && (wb_adr_i == 8'h04 || wb_adr_i == 8'h08);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_timing: assert property (s_req |=> s_ack_once)
        else $error("ack not a single pulse one cycle after request");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_send_cause: assert property (fan_send_o |-> $past(wr_samp))
        else $error("fan level sent without a new sample");
    a_send_single: assert property (fan_send_o |=> !fan_send_o)
        else $error("fan send longer than one cycle");
    a_level_hold: assert property (!fan_send_o |-> $stable(fan_level_o))
        else $error("fan level changed without send");
    a_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data changed without ack");
    a_unmapped_zero: assert property
        (wb_ack_o && $past(!wb_we_i && wb_adr_i[7]) |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst_i |=> !wb_ack_o && !fan_send_o && fan_level_o == 8'h00)
        else $error("outputs not quiet after reset");
endmodule
bind fmh_ctrl fmh_ctrl_assertions u_chk (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .fan_level_o, .fan_send_o);
`default_nettype wire

/* File: dv/fmh_actuator_model.sv */
// fan actuator: keeps the last fan level sent and counts the sends
// assumes the controller's clock and reset
`timescale 1ns/1ps
`default_nettype none
module fmh_actuator_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] fan_level_i,
    input wire logic fan_send_i,
    output logic [7:0] speed_o,
    output logic [7:0] n_rx_o
);
    always @(posedge clk_i) begin
        if (rst_i) begin
            speed_o <= 8'h00;
            n_rx_o <= 8'h00;
        end else if (fan_send_i) begin
            speed_o <= fan_level_i;
            n_rx_o <= n_rx_o + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// testbench for the fan stage controller over its wishbone port
// assumes the bound checker and the actuator model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o;
    wire [7:0] fan_level_o;
    wire fan_send_o;
    wire [7:0] speed;
    wire [7:0] n_rx;
    int n_fail = 0;
    int checks = 0;
    logic [31:0] q;
    logic [7:0] nsend = 8'h00;
    // adr, reset value
    localparam logic [15:0] RV [0:7] = '{16'h0050, 16'h04c8, 16'h08c8,
        16'h0c01, 16'h2000, 16'h240a, 16'h4414, 16'h8000};
    // send, adr, data, fan level byte
    localparam logic [35:0] ST [0:23] = '{36'h1_08_00c6_01,
        36'h0_08_00c7_01, 36'h1_08_00c8_00, 36'h1_08_00bc_02,
        36'h1_08_00b7_03, 36'h1_08_00b2_04, 36'h1_08_00a8_05,
        36'h1_08_00af_04, 36'h1_08_00c8_00, 36'h1_04_00d2_01,
        36'h1_04_00c8_00, 36'h0_00_0052_00, 36'h1_08_00b7_32,
        36'h1_08_00c6_01, 36'h1_08_00c8_00, 36'h0_00_0051_00,
        36'h1_08_00ca_01, 36'h1_08_00d4_02, 36'h0_08_00d3_02,
        36'h1_08_00c8_00, 36'h0_00_0030_00, 36'h1_08_00a8_03,
        36'h1_08_00c8_00, 36'h0_80_00ff_00};
    fmh_ctrl dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .fan_level_o, .fan_send_o);
    fmh_actuator_model u_act (.clk_i, .rst_i, .fan_level_i(fan_level_o),
        .fan_send_i(fan_send_o), .speed_o(speed), .n_rx_o(n_rx));
    always #50 clk_i = ~clk_i;
    task automatic final_report;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wb(input logic [7:0] a, input logic we,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'h3;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        `CHK(wb_ack_o, 1'b1)
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    // write one sample; the actuator takes the level one edge after send
    task automatic sample(input logic [7:0] a, input logic [15:0] d,
                          input logic snd, input logic [7:0] lv);
        wb(a, 1'b1, {16'h0, d});
        #1;
        nsend = nsend + {7'h0, snd};
        `CHK(fan_send_o, snd)
        `CHK(fan_level_o, lv)
        @(posedge clk_i);
        #1;
        `CHK(speed, lv)
    endtask
    initial begin
        #1_000_000;
        n_fail++;
        final_report();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (RV[i]) begin
            wb(RV[i][15:8], 1'b0, 32'h0);
            `CHK(q, {24'h0, RV[i][7:0]})
        end
        $display("test reset_values done");
        foreach (ST[i]) begin
            sample(ST[i][31:24], ST[i][23:8], ST[i][32], ST[i][7:0]);
        end
        $display("test stage_sweep done");
        // hysteresis 0.5 K, stage two offset 1.2 K, level two at 40 percent
        wb(8'h0c, 1'b1, 32'h00000005);
        wb(8'h24, 1'b1, 32'h0000000c);
        wb(8'h44, 1'b1, 32'h00000028);
        wb(8'h00, 1'b1, 32'h00000052);
        sample(8'h08, 16'h00b8, 1'b1, 8'h01);
        sample(8'h08, 16'h00b6, 1'b1, 8'h28);
        wb(8'h10, 1'b0, 32'h0);
        `CHK(q, 32'h00280202)
        sample(8'h08, 16'h00c8, 1'b1, 8'h00);
        $display("test config done");
        wb(8'h80, 1'b0, 32'h0);
        `CHK(q, 32'h0)
        `CHK(n_rx, nsend)
        $display("test unmapped done");
        final_report();
    end
endmodule
`default_nettype wire
